/* rtm_host_model.sv */
// management bus host model driving register strobes and the adaptation start bit
`timescale 1ns/1ps
`default_nettype none
module rtm_host_model (
   // clock
   input wire logic sys_clk,
   // register port
   output logic [7:0] reg_addr,
   output logic reg_wr,
   output logic [7:0] reg_wdata,
   output logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid,
   // start bit of the linear adaptation
   output logic linear_adapt_start
);
   initial begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_wdata = 8'h00;
      reg_rd = 1'b0;
      linear_adapt_start = 1'b0;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      #1;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge sys_clk);
      #1;
      reg_wr = 1'b0;
   endtask : wr
   // answer is registered, so it is present just after the edge that took the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
      @(posedge sys_clk);
      #1;
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge sys_clk);
      #1;
      reg_rd = 1'b0;
      ok = reg_rvalid;
      d = reg_rdata;
   endtask : rd
   // the start bit is a one-cycle pulse; the host model clears it again after the next edge
   task automatic start();
      @(posedge sys_clk);
      #1;
      linear_adapt_start = 1'b1;
      @(posedge sys_clk);
      #1;
      linear_adapt_start = 1'b0;
   endtask : start
endmodule : rtm_host_model
`default_nettype wire

/* rtm_pkg.sv */
// types shared by the retimer register bank and its pattern block
package rtm_pkg;
   typedef enum logic [1:0] {
      RTM_PAT_7,
      RTM_PAT_9,
      RTM_PAT_15,
      RTM_PAT_31
   } rtm_pattern_e;

   typedef enum logic [1:0] {
      RTM_MODE_NONE,
      RTM_MODE_LIN,
      RTM_MODE_LIN_DFE_LIN,
      RTM_MODE_LOCK_DFE_EQ
   } rtm_adapt_mode_e;

   typedef enum logic [1:0] {
      RTM_FOM_INVALID,
      RTM_FOM_HORIZ,
      RTM_FOM_VERT,
      RTM_FOM_BOTH
   } rtm_fom_e;

   typedef enum {
      ADP_IDLE,
      ADP_LIN1,
      ADP_DFE,
      ADP_LIN2
   } rtm_adapt_state_e;
endpackage : rtm_pkg

/* rtm_prbs.sv */
// pseudo-random pattern generator and self-synchronising checker
`timescale 1ns/1ps
`default_nettype none
`include "rtm_regs.svh"

module rtm_prbs (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // control
   input wire logic enable,
   input wire logic [1:0] select,
   // serial data and error count
   input wire logic rx_bit,
   output logic gen_bit,
   output logic [7:0] err_count
);
   logic [`RTM_LFSR_W-1:0] gen_q;
   logic [`RTM_LFSR_W-1:0] chk_q;
   logic gen_fb;
   logic chk_fb;

   function automatic logic feedback(input logic [`RTM_LFSR_W-1:0] sr, input logic [1:0] sel);
      logic fb;
      fb = 1'b0;
      unique case (rtm_pkg::rtm_pattern_e'(sel))
         rtm_pkg::RTM_PAT_7: fb = sr[6] ^ sr[5];
         rtm_pkg::RTM_PAT_9: fb = sr[8] ^ sr[4];
         rtm_pkg::RTM_PAT_15: fb = sr[14] ^ sr[13];
         rtm_pkg::RTM_PAT_31: fb = sr[30] ^ sr[27];
      endcase
      return fb;
   endfunction : feedback

   assign gen_fb = feedback(gen_q, select);
   assign chk_fb = feedback(chk_q, select);

   // a gated clock is modelled as a reseed; disabling reseeds, so off then on restarts both
   always_ff @(posedge sys_clk) begin
      if (!rst_n || !enable) begin
         gen_q <= `RTM_LFSR_SEED;
         gen_bit <= 1'b0;
      end else begin
         gen_q <= {gen_q[`RTM_LFSR_W-2:0], gen_fb};
         gen_bit <= gen_fb;
      end
   end

   // checker predicts each bit from the previous received ones; saturates rather than wraps
   always_ff @(posedge sys_clk) begin
      if (!rst_n || !enable) begin
         chk_q <= `RTM_LFSR_SEED;
         err_count <= 8'h00;
      end else begin
         chk_q <= {chk_q[`RTM_LFSR_W-2:0], rx_bit};
         if (rx_bit != chk_fb && err_count != `RTM_ERR_MAX) begin
            err_count <= err_count + 8'h01;
         end
      end
   end
endmodule : rtm_prbs
`default_nettype wire

/* rtm_regs.svh */
// register offsets, field positions, reset values and pattern constants of the retimer bank
`ifndef RTM_REGS_SVH
`define RTM_REGS_SVH

`define RTM_ADDR_FLAG_PAT 8'h30
`define RTM_ADDR_ADAPT 8'h31
`define RTM_ADDR_INT_THR 8'h32
`define RTM_ADDR_MIN 8'h33

`define RTM_RST_FLAG_PAT 8'h00
`define RTM_RST_ADAPT 8'h20
`define RTM_RST_INT_THR 8'h11
`define RTM_RST_MIN 8'h88

`define RTM_BIT_RANGE_ERR 5
`define RTM_BIT_EYE_FLAG 4
`define RTM_BIT_PAT_CLK 3
`define RTM_PAT_SEL_HI 1
`define RTM_PAT_SEL_LO 0
`define RTM_MODE_HI 6
`define RTM_MODE_LO 5
`define RTM_FOM_HI 4
`define RTM_FOM_LO 3
`define RTM_HORIZ_HI 7
`define RTM_HORIZ_LO 4
`define RTM_VERT_HI 3
`define RTM_VERT_LO 0

// one threshold step is eight counts of measured opening
`define RTM_THR_SCALE 3'h0

`define RTM_LFSR_W 31
`define RTM_LFSR_SEED 31'h7FFFFFFF
`define RTM_ERR_MAX 8'hFF

`endif

/* rtm_regs_top.sv */
// per-channel eye-flag, pattern, adaptation mode and eye-minimum registers
`timescale 1ns/1ps
`default_nettype none
`include "rtm_regs.svh"

module rtm_regs_top (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // register access from the management bus
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   // eye monitor
   input wire logic [7:0] horizontal_eye_opening,
   input wire logic [7:0] vertical_eye_opening,
   input wire logic eye_int_enable,
   input wire logic eye_monitor_range_error,
   // equaliser control
   input wire logic linear_adapt_start,
   input wire logic linear_lock,
   input wire logic linear_optimal,
   input wire logic dfe_done,
   output logic linear_adapt_active,
   output logic dfe_adapt_active,
   output logic adapt_done,
   // pattern path
   input wire logic pattern_rx_bit,
   output logic pattern_tx_bit,
   output logic [7:0] pattern_err_count
);
   logic [7:0] flag_pat_q;
   logic [7:0] adapt_q;
   logic [7:0] int_thr_q;
   logic [7:0] min_q;
   logic eye_flag_q;
   logic range_err_q;
   logic eye_drop;
   logic flag_set;
   logic rd_flag_reg;
   logic wr_flag_reg;
   logic eye_ok;
   logic [1:0] run_mode_q;
   rtm_pkg::rtm_adapt_state_e st_q;
   rtm_pkg::rtm_adapt_state_e st_d;
   logic done_d;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   // opening compared against threshold times eight
   assign eye_drop = (horizontal_eye_opening <
                      {int_thr_q[`RTM_HORIZ_HI:`RTM_HORIZ_LO], `RTM_THR_SCALE}) ||
                     (vertical_eye_opening <
                      {int_thr_q[`RTM_VERT_HI:`RTM_VERT_LO], `RTM_THR_SCALE});
   assign flag_set = eye_int_enable && eye_drop;
   assign rd_flag_reg = reg_rd && reg_addr == `RTM_ADDR_FLAG_PAT;
   assign wr_flag_reg = reg_wr && reg_addr == `RTM_ADDR_FLAG_PAT;

   // writable fields; status bits are not stored here so writes cannot touch them
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         flag_pat_q <= `RTM_RST_FLAG_PAT;
         adapt_q <= `RTM_RST_ADAPT;
         int_thr_q <= `RTM_RST_INT_THR;
         min_q <= `RTM_RST_MIN;
      end else if (reg_wr) begin
         unique case (reg_addr)
            `RTM_ADDR_FLAG_PAT: flag_pat_q <= reg_wdata;
            `RTM_ADDR_ADAPT: adapt_q <= reg_wdata;
            `RTM_ADDR_INT_THR: int_thr_q <= reg_wdata;
            `RTM_ADDR_MIN: min_q <= reg_wdata;
            default: ;
         endcase
      end
   end

   // sticky flag: a new drop in the clearing read's cycle survives it
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         eye_flag_q <= 1'b0;
         range_err_q <= 1'b0;
      end else begin
         eye_flag_q <= (eye_flag_q && !rd_flag_reg) || flag_set;
         range_err_q <= eye_monitor_range_error;
      end
   end

   // read port answers one cycle after the strobe; unmapped offsets read zero
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
         if (reg_rd) begin
            unique case (reg_addr)
               `RTM_ADDR_FLAG_PAT: begin
                  reg_rdata <= flag_pat_q;
                  reg_rdata[`RTM_BIT_EYE_FLAG] <= eye_flag_q;
                  reg_rdata[`RTM_BIT_RANGE_ERR] <= range_err_q;
               end
               `RTM_ADDR_ADAPT: reg_rdata <= adapt_q;
               `RTM_ADDR_INT_THR: reg_rdata <= int_thr_q;
               `RTM_ADDR_MIN: reg_rdata <= min_q;
               default: reg_rdata <= 8'h00;
            endcase
         end
      end
   end

   function automatic logic eye_meets(input logic [1:0] fom, input logic h_ok, input logic v_ok);
      logic ok;
      ok = 1'b0;
      unique case (rtm_pkg::rtm_fom_e'(fom))
         rtm_pkg::RTM_FOM_INVALID: ok = 1'b0;
         rtm_pkg::RTM_FOM_HORIZ: ok = h_ok;
         rtm_pkg::RTM_FOM_VERT: ok = v_ok;
         rtm_pkg::RTM_FOM_BOTH: ok = h_ok && v_ok;
      endcase
      return ok;
   endfunction : eye_meets

   // invalid figure of merit never qualifies, so mode 3 waits rather than guess
   assign eye_ok = eye_meets(adapt_q[`RTM_FOM_HI:`RTM_FOM_LO],
      horizontal_eye_opening >= {min_q[`RTM_HORIZ_HI:`RTM_HORIZ_LO], `RTM_THR_SCALE},
      vertical_eye_opening >= {min_q[`RTM_VERT_HI:`RTM_VERT_LO], `RTM_THR_SCALE});

   always_comb begin
      st_d = st_q;
      done_d = 1'b0;
      unique case (st_q)
         rtm_pkg::ADP_IDLE: if (linear_adapt_start) begin
            if (adapt_q[`RTM_MODE_HI:`RTM_MODE_LO] == rtm_pkg::RTM_MODE_NONE) begin
               done_d = 1'b1;
            end else begin
               st_d = rtm_pkg::ADP_LIN1;
            end
         end
         rtm_pkg::ADP_LIN1: begin
            unique case (rtm_pkg::rtm_adapt_mode_e'(run_mode_q))
               rtm_pkg::RTM_MODE_LOCK_DFE_EQ: if (linear_lock && eye_ok) begin
                  st_d = rtm_pkg::ADP_DFE;
               end
               rtm_pkg::RTM_MODE_LIN_DFE_LIN: if (linear_optimal) begin
                  st_d = rtm_pkg::ADP_DFE;
               end
               default: if (linear_optimal) begin
                  st_d = rtm_pkg::ADP_IDLE;
                  done_d = 1'b1;
               end
            endcase
         end
         rtm_pkg::ADP_DFE: if (dfe_done) begin
            st_d = rtm_pkg::ADP_LIN2;
         end
         rtm_pkg::ADP_LIN2: if (linear_optimal) begin
            st_d = rtm_pkg::ADP_IDLE;
            done_d = 1'b1;
         end
      endcase
   end

   // mode is latched at start so a mid-run write cannot skip a phase
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         st_q <= rtm_pkg::ADP_IDLE;
         run_mode_q <= 2'h0;
         linear_adapt_active <= 1'b0;
         dfe_adapt_active <= 1'b0;
         adapt_done <= 1'b0;
      end else begin
         st_q <= st_d;
         if (st_q == rtm_pkg::ADP_IDLE && linear_adapt_start) begin
            run_mode_q <= adapt_q[`RTM_MODE_HI:`RTM_MODE_LO];
         end
         linear_adapt_active <= st_d == rtm_pkg::ADP_LIN1 || st_d == rtm_pkg::ADP_LIN2;
         dfe_adapt_active <= st_d == rtm_pkg::ADP_DFE;
         adapt_done <= done_d;
      end
   end

   rtm_prbs u_prbs (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .enable(flag_pat_q[`RTM_BIT_PAT_CLK]),
      .select(flag_pat_q[`RTM_PAT_SEL_HI:`RTM_PAT_SEL_LO]),
      .rx_bit(pattern_rx_bit),
      .gen_bit(pattern_tx_bit),
      .err_count(pattern_err_count)
   );

   flag_set_a: assert property (flag_set |=> eye_flag_q)
      else $error("eye drop with enable did not set flag");
   flag_cause_a: assert property ($rose(eye_flag_q) |-> $past(flag_set))
      else $error("eye flag rose without an enabled drop");
   flag_sticky_a: assert property (eye_flag_q && !rd_flag_reg |=> eye_flag_q)
      else $error("eye flag fell without a read");
   flag_clear_a: assert property (rd_flag_reg && eye_flag_q && !flag_set ##1 !flag_set
      |-> !eye_flag_q ##0 reg_rdata[`RTM_BIT_EYE_FLAG])
      else $error("read did not return and clear flag");
   pat_restart_a: assert property (!flag_pat_q[`RTM_BIT_PAT_CLK] |=> pattern_err_count == 8'h00)
      else $error("pattern checker not held while clock gated");
   pat_select_a: assert property (wr_flag_reg |=>
      flag_pat_q[`RTM_PAT_SEL_HI:`RTM_PAT_SEL_LO] ==
      $past(reg_wdata[`RTM_PAT_SEL_HI:`RTM_PAT_SEL_LO]))
      else $error("pattern select did not take write");
   mode_dfe_a: assert property (dfe_adapt_active |-> run_mode_q[1])
      else $error("feedback adaptation in a linear-only mode");
   mode3_min_a: assert property (st_q == rtm_pkg::ADP_LIN1 &&
      run_mode_q == rtm_pkg::RTM_MODE_LOCK_DFE_EQ && !eye_ok |=> !dfe_adapt_active)
      else $error("feedback started before eye minimums met");
   ro_flag_a: assert property (wr_flag_reg && !eye_flag_q && !flag_set |=> !eye_flag_q)
      else $error("write changed read-only flag");
endmodule : rtm_regs_top
`default_nettype wire

/* tb.sv */
// self-checking testbench of the retimer register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, err_cnt;
   logic reg_wr, reg_rd, reg_rvalid, start, lin_act, dfe_act, done, tx;
   logic [7:0] h_open = 8'hC8;
   logic [7:0] v_open = 8'hC8;
   logic int_en = 1'b0;
   logic range_err = 1'b0;
   logic invert = 1'b0;
   logic lock = 1'b1;
   logic opt = 1'b1;
   logic dfe_dn = 1'b1;
   int fail_count = 0;
   int num_checks = 0;
   wire rx = tx ^ invert;
   always #12.5 sys_clk = ~sys_clk;
   rtm_host_model u_host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .linear_adapt_start(start));
   // equaliser status idles high; t_wait pulls the first-phase input and dfe_done low so the first linear and the feedback phase each wait on their own input
   rtm_regs_top u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .horizontal_eye_opening(h_open), .vertical_eye_opening(v_open), .eye_int_enable(int_en),
      .eye_monitor_range_error(range_err), .linear_adapt_start(start), .linear_lock(lock),
      .linear_optimal(opt), .dfe_done(dfe_dn), .linear_adapt_active(lin_act),
      .dfe_adapt_active(dfe_act), .adapt_done(done), .pattern_rx_bit(rx),
      .pattern_tx_bit(tx), .pattern_err_count(err_cnt));
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : conclude
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      logic ok;
      u_host.rd(a, d, ok);
      check({7'h00, ok}, 8'h01);
      check(d, exp);
   endtask : rdchk
   task automatic cycles(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : cycles
   task automatic t_regs();
      rdchk(8'h30, 8'h00);
      rdchk(8'h31, 8'h20);
      rdchk(8'h32, 8'h11);
      rdchk(8'h33, 8'h88);
      u_host.wr(8'h34, 8'hFF);
      rdchk(8'h34, 8'h00);
      u_host.wr(8'h30, 8'hFF);
      rdchk(8'h30, 8'hCF);
      u_host.wr(8'h30, 8'h00);
      range_err = 1'b1;
      cycles(2);
      rdchk(8'h30, 8'h20);
      range_err = 1'b0;
      u_host.wr(8'h33, 8'h5A);
      rdchk(8'h33, 8'h5A);
      u_host.wr(8'h33, 8'h88);
   endtask : t_regs
   // horizontal limit 2 steps = 16, vertical 1 step = 8
   task automatic t_flag();
      u_host.wr(8'h32, 8'h21);
      int_en = 1'b1;
      h_open = 8'h0C;
      cycles(2);
      h_open = 8'hC8;
      cycles(3);
      rdchk(8'h30, 8'h10);
      rdchk(8'h30, 8'h00);
      v_open = 8'h08;
      cycles(3);
      rdchk(8'h30, 8'h00);
      v_open = 8'h07;
      cycles(2);
      v_open = 8'hC8;
      rdchk(8'h30, 8'h10);
      int_en = 1'b0;
      h_open = 8'h00;
      cycles(3);
      rdchk(8'h30, 8'h00);
      h_open = 8'hC8;
   endtask : t_flag
   // a stuck run is freed by a valid figure of merit and an open eye, then passes feedback
   task automatic t_adapt(input logic [1:0] mode, input logic [1:0] fom, input logic [7:0] h,
         input logic [7:0] v, input logic exp_dfe, input logic stuck);
      logic sl, sd, sn;
      sl = 1'b0;
      sd = 1'b0;
      sn = 1'b0;
      u_host.wr(8'h31, {1'b0, mode, fom, 3'b000});
      h_open = h;
      v_open = v;
      u_host.start();
      for (int pass = 0; pass < 2; pass++) begin
         for (int i = 0; i < 30 && !sn; i++) begin
            sl |= lin_act;
            sd |= dfe_act;
            sn |= done;
            cycles(1);
         end
         check({5'h00, sl, sd, sn}, {5'h00, mode != 2'd0, exp_dfe, !stuck});
         if (!stuck) begin
            break;
         end
         u_host.wr(8'h31, {1'b0, mode, 2'd3, 3'b000});
         stuck = 1'b0;
         exp_dfe = 1'b1;
         h_open = 8'hC8;
         v_open = 8'hC8;
      end
      if (!sn) begin
         conclude();
      end
      h_open = 8'hC8;
      v_open = 8'hC8;
   endtask : t_adapt
   // mode 2 must wait on optimal, mode 3 on lock, and both on feedback done
   task automatic t_wait(input logic [1:0] mode);
      u_host.wr(8'h31, {1'b0, mode, 2'd3, 3'b000});
      lock = mode != 2'd3;
      opt = mode == 2'd3;
      dfe_dn = 1'b0;
      u_host.start();
      cycles(5);
      check({5'h00, lin_act, dfe_act, done}, 8'h04);
      lock = 1'b1;
      opt = 1'b1;
      cycles(5);
      check({5'h00, lin_act, dfe_act, done}, 8'h02);
      dfe_dn = 1'b1;
      cycles(5);
      check({5'h00, lin_act, dfe_act, done}, 8'h00);
   endtask : t_wait
   task automatic grab(input logic [1:0] sel, output logic [99:0] s);
      u_host.wr(8'h30, 8'h00);
      u_host.wr(8'h30, {6'h02, sel});
      for (int i = 0; i < 100; i++) begin
         s[i] = tx;
         cycles(1);
      end
   endtask : grab
   task automatic t_pattern(input logic [1:0] sel);
      logic [99:0] s, s2;
      logic ok_a, ok_b;
      int p, q;
      p = (sel == 2'd0) ? 7 : (sel == 2'd1) ? 9 : (sel == 2'd2) ? 15 : 31;
      q = (sel == 2'd0) ? 6 : (sel == 2'd1) ? 5 : (sel == 2'd2) ? 14 : 28;
      ok_a = 1'b1;
      ok_b = 1'b1;
      grab(sel, s);
      grab(sel, s2);
      // s[0] is the held output before the first shift, so it takes no part in the recurrence
      for (int n = 32; n < 100; n++) begin
         ok_a &= (s[n] === (s[n-p] ^ s[n-q]));
         ok_b &= (s[n] === (s[n-p] ^ s[n-p+q]));
      end
      check({7'h00, (ok_a | ok_b) & (|s)}, 8'h01);
      check({7'h00, s === s2}, 8'h01);
   endtask : t_pattern
   // a flipped stream breaks every prediction, a looped one none once aligned
   task automatic t_checker();
      logic [7:0] c1;
      c1 = err_cnt;
      cycles(20);
      check(err_cnt, c1);
      invert = 1'b1;
      cycles(20);
      check({7'h00, err_cnt > c1 + 8'd10}, 8'h01);
      invert = 1'b0;
      u_host.wr(8'h30, 8'h00);
      cycles(2);
      check(err_cnt, 8'h00);
   endtask : t_checker
   initial begin
      repeat (4) @(posedge sys_clk);
      #1;
      rst_n = 1'b1;
      t_regs();
      t_flag();
      t_adapt(2'd0, 2'd3, 8'hC8, 8'hC8, 1'b0, 1'b0);
      t_adapt(2'd1, 2'd3, 8'hC8, 8'hC8, 1'b0, 1'b0);
      t_adapt(2'd2, 2'd3, 8'hC8, 8'hC8, 1'b1, 1'b0);
      t_adapt(2'd3, 2'd3, 8'hC8, 8'hC8, 1'b1, 1'b0);
      t_adapt(2'd3, 2'd0, 8'hC8, 8'hC8, 1'b0, 1'b1);
      t_adapt(2'd3, 2'd1, 8'h40, 8'h00, 1'b1, 1'b0);
      t_adapt(2'd3, 2'd1, 8'h3F, 8'hC8, 1'b0, 1'b1);
      t_adapt(2'd3, 2'd2, 8'h00, 8'h40, 1'b1, 1'b0);
      t_adapt(2'd3, 2'd3, 8'hC8, 8'h3F, 1'b0, 1'b1);
      t_wait(2'd2);
      t_wait(2'd3);
      for (int sel = 0; sel < 4; sel++) begin
         t_pattern(sel[1:0]);
      end
      t_checker();
      conclude();
   end
endmodule : tb
`default_nettype wire
